/* File: hdl/sdb_bridge.sv */
// Bridge end: register bank, card clock enables, word/nibble FIFOs.
// Assumes the core end on the link and a single-cycle register port.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Card rate from two-bit choice
// - Slow rate by counter, 25M/50M by phase counter, 100M every cycle
// - Ack in set-reset flop, choice latched
// - Request with choice; ack until switched
// - Busy falling edge raises interrupt
// - Two FIFOs convert words and nibbles
// - Receive ready low when room exceeds block
// - Transmit ready low when block held
// - Flags: memory init, card, busy
// - Fault 0: init timeout, auto clears
// - Fault 1: response timeout, reset clears
// - Fault 2: write CRC status, aborts write
// - Fault 3: read CRC, aborts read
// - Command: request pulse, reset, direction
// - Remaining block count readable
// - Write-only buffer base addresses
// - Software gives legal start and count
// - Core busy acknowledges request until done
// - Command clock at least 20 MHz
// - Voltage settle delay tied constant
// - Low voltage select survives core reset
// - Core reset active low
module sdb_bridge
  import sdb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  sdb_link_if.bridge       link,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  input  wire logic        mem_init_done,
  input  wire logic        card_present_n,
  input  wire logic [31:0] tx_mem_data,
  input  wire logic        tx_mem_valid,
  output logic             tx_mem_ready,
  output logic [31:0]      rx_mem_data,
  output logic             rx_mem_valid,
  input  wire logic        rx_mem_ready,
  output logic [31:0]      tx_base,
  output logic [31:0]      rx_base,
  output logic             irq
);
  // Register bank
  logic [31:0] start_ff, count_ff, remain_ff;
  logic        dir_ff, req_ff, crst_n_ff;
  logic [9:0]  blk_nib_ff;

  wire wr_tx_base = reg_wr && (reg_addr == OFS_TX_BASE);
  wire wr_rx_base = reg_wr && (reg_addr == OFS_RX_BASE);
  wire wr_command = reg_wr && (reg_addr == OFS_COMMAND);
  wire wr_start   = reg_wr && (reg_addr == OFS_START);
  wire wr_count   = reg_wr && (reg_addr == OFS_COUNT);
  wire wr_go      = wr_command && reg_wdata[CMD_REQ_BIT];

  logic busy_s_ff, busy_d_ff;
  wire [31:0] flags_word = {23'h00_0000, mem_init_done, 6'h00,
                            card_present_n, busy_s_ff};
  wire [31:0] rd_mux =
    (reg_addr == OFS_FLAGS)    ? flags_word :
    (reg_addr == OFS_FAULT)    ? {28'h000_0000, link.fault} :
    (reg_addr == OFS_REMAIN)   ? remain_ff :
    (reg_addr == OFS_CAPACITY) ? link.card_capacity_blocks :
                                 32'h0000_0000;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) reg_rdata <= 32'h0000_0000;
    else reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_base   <= 32'h0000_0000;
      rx_base   <= 32'h0000_0000;
      start_ff  <= 32'h0000_0000;
      count_ff  <= 32'h0000_0000;
      dir_ff    <= 1'b0;
      req_ff    <= 1'b0;
      crst_n_ff <= 1'b1;
    end else begin
      if (wr_tx_base) tx_base <= reg_wdata;
      if (wr_rx_base) rx_base <= reg_wdata;
      if (wr_start) start_ff <= reg_wdata;
      if (wr_count) count_ff <= reg_wdata;
      req_ff <= wr_go;
      if (wr_command) begin
        dir_ff    <= reg_wdata[CMD_DIR_BIT];
        crst_n_ff <= ~reg_wdata[CMD_RESET_BIT];
      end
    end
  end

  // Completion interrupt: busy passed through two stages first
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      busy_s_ff <= 1'b0;
      busy_d_ff <= 1'b0;
      irq       <= 1'b0;
    end else begin
      busy_s_ff <= link.busy;
      busy_d_ff <= busy_s_ff;
      irq       <= busy_d_ff & ~busy_s_ff;
    end
  end

  // Card clock: slow enable by counter, 25M and 50M by phase counter, 100M every cycle
  logic [7:0] div_ff;
  logic [1:0] ph_ff;
  logic [1:0] sel_ff;
  logic       ack_ff, creq_d_ff, cen_ff;
  logic [2:0] settle_ff;
  wire div_wrap = (div_ff == 8'(DIV_SLOW - 1));
  wire en_mid   = (ph_ff == 2'(DIV_MID - 1));
  wire en_high  = (ph_ff[0] == 1'(DIV_HIGH - 1));
  wire en_pick  = (sel_ff == CLK_SEL_400K) ? div_wrap :
                  (sel_ff == CLK_SEL_25M)  ? en_mid :
                  (sel_ff == CLK_SEL_50M)  ? en_high : 1'b1;
  wire sw_set   = link.clock_change_request & ~creq_d_ff & ~ack_ff;
  wire sw_clr   = ack_ff && (settle_ff == 3'h0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= 8'h00;
      ph_ff  <= 2'h0;
      cen_ff <= 1'b0;
    end else begin
      div_ff <= div_wrap ? 8'h00 : div_ff + 8'h01;
      ph_ff  <= ph_ff + 2'h1;
      // Enable held off during a switch, so no runt card cycle
      cen_ff <= en_pick & ~ack_ff & ~sw_set;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff    <= 1'b0;
      creq_d_ff <= 1'b0;
      sel_ff    <= CLK_SEL_400K;
      settle_ff <= 3'h0;
    end else begin
      creq_d_ff <= link.clock_change_request;
      if (sw_set) begin
        ack_ff    <= 1'b1;
        sel_ff    <= link.clock_choice;
        settle_ff <= CLK_SETTLE;
      end else if (sw_clr) begin
        ack_ff <= 1'b0;
      end else if (ack_ff) begin
        settle_ff <= settle_ff - 3'h1;
      end
    end
  end

  // Transmit FIFO: words in, nibbles out, low nibble first
  logic [31:0]        tx_mem [FIFO_WORDS];
  logic [FIFO_AW:0]   txw_ff, txr_ff;
  logic [2:0]         txn_ff;
  logic [3:0]         txd_ff;
  logic               txav_n_ff;
  wire [FIFO_AW:0]  tx_used  = txw_ff - txr_ff;
  wire              tx_in    = tx_mem_valid & tx_mem_ready;
  wire              tx_out   = link.tx_pop & link.card_clk_en &
                               (tx_used != 10'h000);
  wire              tx_wadv  = tx_out && (txn_ff == 3'h7);
  wire [FIFO_AW:0]  nxt_txw  = txw_ff + {9'h000, tx_in};
  wire [FIFO_AW:0]  nxt_txr  = txr_ff + {9'h000, tx_wadv};
  wire [2:0]        nxt_txn  = txn_ff + {2'h0, tx_out};
  wire [FIFO_AW:0]  nxt_txu  = nxt_txw - nxt_txr;
  wire [12:0]       nxt_txl  = {nxt_txu, 3'h0} - {10'h000, nxt_txn};
  wire [FIFO_AW-1:0] tx_ra   = txr_ff[FIFO_AW-1:0];

  always_ff @(posedge clk) begin
    if (tx_in) tx_mem[txw_ff[FIFO_AW-1:0]] <= tx_mem_data;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      txw_ff       <= 10'h000;
      txr_ff       <= 10'h000;
      txn_ff       <= 3'h0;
      txd_ff       <= 4'h0;
      txav_n_ff    <= 1'b1;
      tx_mem_ready <= 1'b0;
    end else begin
      txw_ff       <= nxt_txw;
      txr_ff       <= nxt_txr;
      txn_ff       <= nxt_txn;
      if (tx_out) txd_ff <= tx_mem[tx_ra][{txn_ff, 2'h0} +: 4];
      txav_n_ff    <= ~(nxt_txl >= BLOCK_NIBS);
      tx_mem_ready <= (nxt_txu != FIFO_DEPTH);
    end
  end

  // Receive FIFO: nibbles gathered into words, words out
  logic [31:0]        rx_mem [FIFO_WORDS];
  logic [FIFO_AW:0]   rxw_ff, rxr_ff;
  logic [2:0]         rxn_ff;
  logic [27:0]        rxacc_ff;
  logic               rxroom_n_ff;
  wire [FIFO_AW:0]  rx_used  = rxw_ff - rxr_ff;
  wire              rx_in    = link.rx_push & link.card_clk_en &
                               (rx_used != FIFO_DEPTH);
  wire              rx_wadv  = rx_in && (rxn_ff == 3'h7);
  wire              rx_load  = (rx_used != 10'h000) &&
                               (!rx_mem_valid || rx_mem_ready);
  wire [FIFO_AW:0]  nxt_rxw  = rxw_ff + {9'h000, rx_wadv};
  wire [FIFO_AW:0]  nxt_rxr  = rxr_ff + {9'h000, rx_load};
  wire [2:0]        nxt_rxn  = rxn_ff + {2'h0, rx_in};
  wire [FIFO_AW:0]  nxt_rxf  = FIFO_DEPTH - (nxt_rxw - nxt_rxr);
  wire [12:0]       nxt_rxs  = {nxt_rxf, 3'h0} - {10'h000, nxt_rxn};

  always_ff @(posedge clk) begin
    if (rx_wadv)
      rx_mem[rxw_ff[FIFO_AW-1:0]] <= {link.rx_nibble, rxacc_ff};
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxw_ff       <= 10'h000;
      rxr_ff       <= 10'h000;
      rxn_ff       <= 3'h0;
      rxacc_ff     <= 28'h000_0000;
      rxroom_n_ff  <= 1'b1;
      rx_mem_valid <= 1'b0;
      rx_mem_data  <= 32'h0000_0000;
    end else begin
      rxw_ff <= nxt_rxw;
      rxr_ff <= nxt_rxr;
      rxn_ff <= nxt_rxn;
      if (rx_in && !rx_wadv)
        rxacc_ff[{rxn_ff, 2'h0} +: 4] <= link.rx_nibble;
      rxroom_n_ff <= ~(nxt_rxs > BLOCK_NIBS);
      if (rx_load) begin
        rx_mem_data  <= rx_mem[rxr_ff[FIFO_AW-1:0]];
        rx_mem_valid <= 1'b1;
      end else if (rx_mem_ready) begin
        rx_mem_valid <= 1'b0;
      end
    end
  end

  // Blocks still to move, counted on nibbles through either FIFO
  wire moved   = tx_out | rx_in;
  wire blk_end = moved && (blk_nib_ff == BLOCK_LAST);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      remain_ff  <= 32'h0000_0000;
      blk_nib_ff <= 10'h000;
    end else if (wr_go) begin
      remain_ff  <= count_ff;
      blk_nib_ff <= 10'h000;
    end else if (moved) begin
      blk_nib_ff <= blk_nib_ff + 10'h001;
      if (blk_end && remain_ff != 32'h0000_0000)
        remain_ff <= remain_ff - 32'h0000_0001;
    end
  end

  // Core command clock is clk itself, well above the minimum
  assign link.card_clk_en          = cen_ff;
  assign link.clock_change_ack     = ack_ff;
  assign link.transfer_request     = req_ff;
  assign link.direction_select     = dir_ff;
  assign link.start_block          = start_ff;
  assign link.block_count          = count_ff;
  assign link.core_reset_n         = crst_n_ff;
  assign link.rx_room_n            = rxroom_n_ff;
  assign link.tx_nibble            = txd_ff;
  assign link.tx_block_avail_n     = txav_n_ff;
  assign link.voltage_settle_delay = VSETTLE_STEPS;
endmodule // sdb_bridge
`default_nettype wire

/* File: include/sdb_pkg.sv */
// Constants shared by the bridge end and the core end.
// Assumes one 100 MHz system clock for both ends.
`default_nettype none
package sdb_pkg;
  localparam int SYS_CLK_HZ     = 100_000_000;
  localparam int CARD_HZ_SLOW   = 400_000;
  localparam int CARD_HZ_MID    = 25_000_000;
  localparam int CARD_HZ_HIGH   = 50_000_000;
  localparam int DIV_SLOW       = SYS_CLK_HZ / CARD_HZ_SLOW;
  localparam int DIV_MID        = SYS_CLK_HZ / CARD_HZ_MID;
  localparam int DIV_HIGH       = SYS_CLK_HZ / CARD_HZ_HIGH;
  localparam int CMD_CLK_MIN_HZ = 20_000_000;

  localparam logic [1:0] CLK_SEL_400K = 2'h0;
  localparam logic [1:0] CLK_SEL_25M  = 2'h1;
  localparam logic [1:0] CLK_SEL_50M  = 2'h2;
  localparam logic [1:0] CLK_SEL_100M = 2'h3;
  localparam logic [2:0] CLK_SETTLE   = 3'h4;

  localparam logic [7:0] OFS_FLAGS    = 8'h00;
  localparam logic [7:0] OFS_TX_BASE  = 8'h00;
  localparam logic [7:0] OFS_FAULT    = 8'h04;
  localparam logic [7:0] OFS_RX_BASE  = 8'h04;
  localparam logic [7:0] OFS_REMAIN   = 8'h08;
  localparam logic [7:0] OFS_COMMAND  = 8'h08;
  localparam logic [7:0] OFS_CAPACITY = 8'h0C;
  localparam logic [7:0] OFS_START    = 8'h0C;
  localparam logic [7:0] OFS_COUNT    = 8'h10;

  localparam int CMD_REQ_BIT   = 0;
  localparam int CMD_RESET_BIT = 8;
  localparam int CMD_DIR_BIT   = 31;
  localparam int FLG_BUSY_BIT  = 0;
  localparam int FLG_CARD_BIT  = 1;
  localparam int FLG_MINIT_BIT = 8;

  localparam int FLT_INIT_TMO   = 0;
  localparam int FLT_RESP_TMO   = 1;
  localparam int FLT_CRC_STATUS = 2;
  localparam int FLT_CRC_DATA   = 3;

  localparam int         BLOCK_BYTES = 512;
  localparam logic [9:0] BLOCK_LAST  = 10'h3FF;
  localparam logic [12:0] BLOCK_NIBS = 13'h0400;
  localparam int         FIFO_WORDS  = 512;
  localparam int         FIFO_AW     = 9;
  localparam logic [9:0] FIFO_DEPTH  = 10'h200;

  localparam int         VSETTLE_STEP_US = 1300;
  localparam logic [7:0] VSETTLE_STEPS   = 8'h0A;
endpackage
`default_nettype wire

/* File: include/sdb_link_if.sv */
// Connection between the bridge and the card host core.
// Assumes both ends share clk and rstn.
`timescale 1ns/1ps
`default_nettype none
interface sdb_link_if (
  input wire logic clk,
  input wire logic rstn
);
  logic        card_clk_en;
  logic [1:0]  clock_choice;
  logic        clock_change_request;
  logic        clock_change_ack;
  logic        transfer_request;
  logic        direction_select;
  logic [31:0] start_block;
  logic [31:0] block_count;
  logic        busy;
  logic [31:0] card_capacity_blocks;
  logic [3:0]  fault;
  logic        core_reset_n;
  logic [3:0]  rx_nibble;
  logic        rx_push;
  logic        rx_room_n;
  logic [3:0]  tx_nibble;
  logic        tx_pop;
  logic        tx_block_avail_n;
  logic [7:0]  voltage_settle_delay;
  logic        low_voltage_select;

  modport bridge (
    output card_clk_en, clock_change_ack, transfer_request,
    output direction_select, start_block, block_count, core_reset_n,
    output rx_room_n, tx_nibble, tx_block_avail_n, voltage_settle_delay,
    input  clock_choice, clock_change_request, busy, card_capacity_blocks,
    input  fault, rx_nibble, rx_push, tx_pop, low_voltage_select
  );
  modport core (
    input  card_clk_en, clock_change_ack, transfer_request,
    input  direction_select, start_block, block_count, core_reset_n,
    input  rx_room_n, tx_nibble, tx_block_avail_n, voltage_settle_delay,
    output clock_choice, clock_change_request, busy, card_capacity_blocks,
    output fault, rx_nibble, rx_push, tx_pop, low_voltage_select
  );
endinterface
`default_nettype wire

/* File: hdl/sdb_core_end.sv */
// Card host core end: clock-change requests, transfers, fault flags.
// Assumes the bridge end on the link; outcomes come from user ports.
`timescale 1ns/1ps
`default_nettype none
module sdb_core_end
  import sdb_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  sdb_link_if.core         link,
  input  wire logic [1:0]  usr_clk_choice,
  input  wire logic        usr_clk_change,
  input  wire logic [31:0] usr_capacity,
  input  wire logic        usr_init_done,
  input  wire logic        usr_init_timeout,
  input  wire logic        usr_resp_timeout,
  input  wire logic        usr_crc_status_bad,
  input  wire logic        usr_crc_data_bad,
  input  wire logic        usr_low_voltage_go,
  input  wire logic        card_present_n,
  input  wire logic [3:0]  usr_rx_nibble,
  output logic [3:0]       usr_last_tx_nibble,
  output logic             usr_clk_switching
);
  typedef enum logic [1:0] {ST_INIT, ST_IDLE, ST_WRITE, ST_READ} sdb_cst_t;
  sdb_cst_t    st_ff;
  sdb_cst_t    nxt_st;
  logic [31:0] left_ff;
  logic [9:0]  nib_ff;
  logic        pop_ff, push_ff, req_ff, busy_ff, lv_ff;
  logic [1:0]  sel_ff;
  logic [3:0]  flt_ff, nxt_flt, rxn_ff, txn_ff;

  wire soft_rst  = ~link.core_reset_n;
  wire active    = (st_ff == ST_WRITE) || (st_ff == ST_READ);
  wire flag_n    = (st_ff == ST_WRITE) ? link.tx_block_avail_n
                                       : link.rx_room_n;
  wire xfer_nib  = (pop_ff | push_ff) & link.card_clk_en;
  wire blk_end   = xfer_nib && (nib_ff == BLOCK_LAST);
  wire last_blk  = blk_end && (left_ff == 32'h0000_0001);
  wire abort     = ((st_ff == ST_WRITE) && usr_crc_status_bad) ||
                   ((st_ff == ST_READ) && usr_crc_data_bad);
  wire start     = (st_ff == ST_IDLE) && link.transfer_request;
  wire moving    = pop_ff | push_ff;
  wire nxt_move  = active && !abort && !last_blk &&
                   (moving ? !blk_end : (!flag_n && left_ff != 0));

  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      ST_INIT:  if (usr_init_done && !card_present_n) nxt_st = ST_IDLE;
      ST_IDLE:  if (start) nxt_st = link.direction_select ? ST_READ
                                                          : ST_WRITE;
      default:  if (abort || last_blk) nxt_st = ST_IDLE;
    endcase
    if (card_present_n) nxt_st = ST_INIT;
  end

  always_comb begin
    nxt_flt = flt_ff;
    if (usr_init_timeout) nxt_flt[FLT_INIT_TMO] = 1'b1;
    else if (usr_init_done) nxt_flt[FLT_INIT_TMO] = 1'b0;
    if (usr_resp_timeout) nxt_flt[FLT_RESP_TMO] = 1'b1;
    else if (card_present_n) nxt_flt[FLT_RESP_TMO] = 1'b0;
    if (start && !link.direction_select)
      nxt_flt[FLT_CRC_STATUS] = 1'b0;
    if (usr_crc_status_bad && st_ff == ST_WRITE)
      nxt_flt[FLT_CRC_STATUS] = 1'b1;
    if (start && link.direction_select)
      nxt_flt[FLT_CRC_DATA] = 1'b0;
    if (usr_crc_data_bad && st_ff == ST_READ)
      nxt_flt[FLT_CRC_DATA] = 1'b1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff   <= ST_INIT;
      flt_ff  <= 4'h0;
      busy_ff <= 1'b1;
      left_ff <= 32'h0000_0000;
      nib_ff  <= 10'h000;
      pop_ff  <= 1'b0;
      push_ff <= 1'b0;
    end else if (soft_rst) begin
      st_ff   <= ST_INIT;
      flt_ff  <= 4'h0;
      busy_ff <= 1'b1;
      pop_ff  <= 1'b0;
      push_ff <= 1'b0;
      nib_ff  <= 10'h000;
    end else begin
      st_ff   <= nxt_st;
      flt_ff  <= nxt_flt;
      busy_ff <= (nxt_st != ST_IDLE);
      if (start) left_ff <= link.block_count;
      else if (blk_end) left_ff <= left_ff - 32'h0000_0001;
      if (start || abort) nib_ff <= 10'h000;
      else if (xfer_nib) nib_ff <= nib_ff + 10'h001;
      pop_ff  <= nxt_move && (st_ff == ST_WRITE);
      push_ff <= nxt_move && (st_ff == ST_READ);
    end
  end

  // Select level survives the core reset; only power or removal clears it
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) lv_ff <= 1'b0;
    else if (card_present_n) lv_ff <= 1'b0;
    else if (usr_low_voltage_go) lv_ff <= 1'b1;
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      req_ff            <= 1'b0;
      sel_ff            <= CLK_SEL_400K;
      usr_clk_switching <= 1'b0;
    end else begin
      if (link.clock_change_ack) req_ff <= 1'b0;
      else if (usr_clk_change && !req_ff) begin
        req_ff <= 1'b1;
        sel_ff <= usr_clk_choice;
      end
      usr_clk_switching <= req_ff | link.clock_change_ack;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rxn_ff             <= 4'h0;
      txn_ff             <= 4'h0;
      usr_last_tx_nibble <= 4'h0;
    end else begin
      rxn_ff <= usr_rx_nibble;
      txn_ff <= link.tx_nibble;
      usr_last_tx_nibble <= txn_ff;
    end
  end

  assign link.clock_choice         = sel_ff;
  assign link.clock_change_request = req_ff;
  assign link.busy                 = busy_ff;
  assign link.card_capacity_blocks = usr_capacity;
  assign link.fault                = flt_ff;
  assign link.rx_nibble            = rxn_ff;
  assign link.rx_push              = push_ff;
  assign link.tx_pop               = pop_ff;
  assign link.low_voltage_select   = lv_ff;
endmodule // sdb_core_end
`default_nettype wire

/* File: sim/sdb_monitor.sv */
// Checker on the link between bridge end and core end.
// Assumes one clock; the bench wires it beside the link.
`timescale 1ns/1ps
`default_nettype none
module sdb_monitor
  import sdb_pkg::*;
(
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       card_clk_en,
  input wire logic [1:0] clock_choice,
  input wire logic       clock_change_request,
  input wire logic       clock_change_ack,
  input wire logic       transfer_request,
  input wire logic       busy,
  input wire logic [3:0] fault,
  input wire logic       core_reset_n,
  input wire logic [7:0] voltage_settle_delay,
  input wire logic       low_voltage_select
);
  logic [1:0] sel_ff;
  wire        sw = clock_change_request | clock_change_ack;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // Same capture point as the bridge: the request's rising edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) sel_ff <= 2'h0;
    else if ($rose(clock_change_request)) sel_ff <= clock_choice;
  end
  property p_take;
    $rose(clock_change_request) && !clock_change_ack |=> clock_change_ack;
  endproperty
  a_take: assert property (p_take) else $error("ack late");
  property p_hold;
    $rose(clock_change_ack) |-> clock_change_ack[*5] ##1 !clock_change_ack;
  endproperty
  a_hold: assert property (p_hold) else $error("ack length");
  property p_quiet;
    clock_change_ack |-> !card_clk_en;
  endproperty
  a_quiet: assert property (p_quiet) else $error("enable in switch");
  // Rate checks pause while a switch is under way
  property p_slow;
    disable iff (!rstn || sw)
    card_clk_en && sel_ff == CLK_SEL_400K |=> !card_clk_en[*8];
  endproperty
  a_slow: assert property (p_slow) else $error("slow rate");
  property p_mid;
    disable iff (!rstn || sw)
    card_clk_en && sel_ff == CLK_SEL_25M |=> !card_clk_en[*3] ##1 card_clk_en;
  endproperty
  a_mid: assert property (p_mid) else $error("25M rate");
  property p_high;
    disable iff (!rstn || sw)
    card_clk_en && sel_ff == CLK_SEL_50M |=> !card_clk_en ##1 card_clk_en;
  endproperty
  a_high: assert property (p_high) else $error("50M rate");
  property p_full;
    disable iff (!rstn || sw)
    card_clk_en && sel_ff == CLK_SEL_100M |=> card_clk_en;
  endproperty
  a_full: assert property (p_full) else $error("100M rate");
  property p_req;
    transfer_request |=> busy && !transfer_request;
  endproperty
  a_req: assert property (p_req) else $error("request pulse");
  property p_crst;
    !core_reset_n |=> busy && !fault[1];
  endproperty
  a_crst: assert property (p_crst) else $error("core reset");
  property p_lv;
    low_voltage_select && !core_reset_n |=> low_voltage_select;
  endproperty
  a_lv: assert property (p_lv) else $error("low voltage lost");
  property p_vset;
    voltage_settle_delay != 8'h00 && $stable(voltage_settle_delay);
  endproperty
  a_vset: assert property (p_vset) else $error("settle delay");
endmodule // sdb_monitor
`default_nettype wire

/* File: sim/sdb_bridge_bench.sv */
// Bench joining bridge end and core end over the link.
// Assumes package and link interface compiled first.
`timescale 1ns/1ps
`default_nettype none
module sdb_bridge_bench;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata, tx_base, rx_base, rx_data;
  logic [31:0] tx_data = 32'h0000_0000;
  logic        tx_valid = 1'b0;
  logic        tx_ready, rx_valid, irq, switching;
  logic        rx_ready = 1'b0;
  logic        present_n = 1'b0;
  logic [1:0]  csel = 2'h0;
  logic        cchg = 1'b0;
  logic        idone = 1'b0;
  logic [3:0]  flt = 4'h0;
  logic        lv_go = 1'b0;
  logic [3:0]  last_nib;
  int          fails = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          irqs = 0;
  int          n, got;
  wire         av_n = sdb_link_if_inst.tx_block_avail_n;
  wire         lvs  = sdb_link_if_inst.low_voltage_select;
  always #5 clk = ~clk;
  sdb_link_if sdb_link_if_inst (.clk(clk), .rstn(rstn));
  sdb_bridge sdb_bridge_inst (.clk(clk), .rstn(rstn), .link(sdb_link_if_inst),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata), .mem_init_done(1'b1), .card_present_n(present_n),
    .tx_mem_data(tx_data), .tx_mem_valid(tx_valid), .tx_mem_ready(tx_ready),
    .rx_mem_data(rx_data), .rx_mem_valid(rx_valid), .rx_mem_ready(rx_ready),
    .tx_base(tx_base), .rx_base(rx_base), .irq(irq));
  sdb_core_end sdb_core_end_inst (.clk(clk), .rstn(rstn),
    .link(sdb_link_if_inst), .usr_clk_choice(csel), .usr_clk_change(cchg),
    .usr_capacity(32'h0001_2340), .usr_init_done(idone),
    .usr_init_timeout(flt[0]), .usr_resp_timeout(flt[1]),
    .usr_crc_status_bad(flt[2]), .usr_crc_data_bad(flt[3]),
    .usr_low_voltage_go(lv_go), .card_present_n(present_n),
    .usr_rx_nibble(4'h5), .usr_last_tx_nibble(last_nib),
    .usr_clk_switching(switching));
  sdb_monitor sdb_monitor_inst (.clk(clk), .rstn(rstn),
    .card_clk_en(sdb_link_if_inst.card_clk_en),
    .clock_choice(sdb_link_if_inst.clock_choice),
    .clock_change_request(sdb_link_if_inst.clock_change_request),
    .clock_change_ack(sdb_link_if_inst.clock_change_ack),
    .transfer_request(sdb_link_if_inst.transfer_request),
    .busy(sdb_link_if_inst.busy), .fault(sdb_link_if_inst.fault),
    .core_reset_n(sdb_link_if_inst.core_reset_n),
    .voltage_settle_delay(sdb_link_if_inst.voltage_settle_delay),
    .low_voltage_select(sdb_link_if_inst.low_voltage_select));
  // A wide pulse shows up here as extra counts
  always @(posedge clk) if (irq === 1'b1) irqs++;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    if (fails == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got_v, exp);
    total_checks++;
    if (got_v !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got_v);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask
  task automatic wait_irq(input int k);
    for (n = 0; n < 4000 && irqs < k; n++) @(posedge clk);
    chk("irq count", 32'(irqs), 32'(k));
  endtask
  task automatic clk_sw(input logic [1:0] s);
    @(posedge clk);
    csel <= s;
    cchg <= 1'b1;
    @(posedge clk);
    cchg <= 1'b0;
    @(posedge clk);
    #1 chk("switching", 32'(switching), 32'h0000_0001);
    repeat (300) @(posedge clk);
    chk("switching", 32'(switching), 32'h0000_0000);
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    chk("tx avail", 32'(av_n), 32'h0000_0001);
    rd_reg("flags", 8'h00, 32'h0000_0101);
    rd_reg("capacity", 8'h0C, 32'h0001_2340);
    rd_reg("unmapped", 8'h14, 32'h0000_0000);
    chk("rx room", 32'(sdb_link_if_inst.rx_room_n), 32'h0000_0000);
    idone <= 1'b1;
    wait_irq(1);
    wr_reg(8'h00, 32'h9000_0000);
    wr_reg(8'h04, 32'h9800_0000);
    #1 chk("tx base", tx_base, 32'h9000_0000);
    chk("rx base", rx_base, 32'h9800_0000);
    rd_reg("flags", 8'h00, 32'h0000_0100);
    for (int s = 0; s < 4; s++) clk_sw(2'(s));
    flt <= 4'hE;
    lv_go <= 1'b1;
    @(posedge clk);
    flt <= 4'h0;
    lv_go <= 1'b0;
    rd_reg("faults", 8'h04, 32'h0000_0002);
    wr_reg(8'h10, 32'h0000_0001);
    wr_reg(8'h0C, 32'h0000_0000);
    tx_valid <= 1'b1;
    tx_data <= 32'hC000_0000;
    for (n = 0; n < 256;) begin
      @(posedge clk);
      if (tx_ready === 1'b1) begin
        n++;
        tx_data <= 32'hC000_0000 | 32'(n);
      end
    end
    tx_valid <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk("tx avail", 32'(av_n), 32'h0000_0000);
    wr_reg(8'h08, 32'h0000_0001);
    rd_reg("remain", 8'h08, 32'h0000_0001);
    wait_irq(2);
    rd_reg("remain", 8'h08, 32'h0000_0000);
    chk("last nibble", 32'(last_nib), 32'h0000_000C);
    rd_reg("faults", 8'h04, 32'h0000_0002);
    rx_ready <= 1'b1;
    wr_reg(8'h08, 32'h8000_0001);
    got = 0;
    // Counted at the falling edge, where valid is settled
    for (n = 0; n < 4000 && got < 128; n++) begin
      @(negedge clk);
      if (rx_valid === 1'b1) begin
        got++;
        chk("rx word", rx_data, 32'h5555_5555);
      end
    end
    chk("rx words", 32'(got), 32'h0000_0080);
    wait_irq(3);
    rd_reg("faults", 8'h04, 32'h0000_0002);
    wr_reg(8'h08, 32'h0000_0100);
    rd_reg("faults", 8'h04, 32'h0000_0000);
    repeat (3) @(posedge clk);
    rd_reg("flags", 8'h00, 32'h0000_0101);
    chk("lv", 32'(lvs), 32'h0000_0001);
    wr_reg(8'h08, 32'h0000_0000);
    wait_irq(4);
    wr_reg(8'h08, 32'h0000_0001);
    @(posedge clk);
    flt <= 4'h4;
    @(posedge clk);
    flt <= 4'h0;
    wait_irq(5);
    rd_reg("faults", 8'h04, 32'h0000_0004);
    wr_reg(8'h08, 32'h8000_0001);
    @(posedge clk);
    flt <= 4'h8;
    @(posedge clk);
    flt <= 4'h0;
    wait_irq(6);
    rd_reg("faults", 8'h04, 32'h0000_000C);
    present_n <= 1'b1;
    repeat (4) @(posedge clk);
    rd_reg("flags", 8'h00, 32'h0000_0103);
    chk("lv", 32'(lvs), 32'h0000_0000);
    repeat (8) @(posedge clk);
    chk("irq total", 32'(irqs), 32'h0000_0006);
    summarize();
  end
endmodule // sdb_bridge_bench
`default_nettype wire
